// ### logic/pls_pkg.sv
// Constants, types and helpers shared by the parallel-link destination.
// Assumes the link runs on its own source-made clock and the user side on clk_sys.
// How it works
// - data bus carries I-word, burst words and checkwords; 32 bits here, 64 optional
// - destination ignores all source signals except clock and interconnect without request
// - connect rises only with interconnect and request, after info word is taken
// - rejection holds connect four to sixteen periods, never issuing ready
// - connect drops when interconnect or request is false, or on hangup
// - after dropping connect, wait for request false then true again
// - after connect, one ready pulse per acceptable burst
// - ready drops whenever connect is deasserted
// - ready counts are cleared before each new connection
// - interconnect going false sends the end to its lost state anytime
// - sequence errors go to the error state and outrank parity or checkword
// - without interconnect every other incoming link signal is invalid
package pls_pkg;

    localparam int DATA_W         = 32;
    localparam int PAR_W          = DATA_W / 8;
    localparam int BURST_MAX      = 256;
    localparam int WCNT_W         = 9;
    localparam int SEED_W         = 8;
    localparam int REJECT_MIN     = 4;
    localparam int REJECT_MAX     = 16;
    localparam int REJECT_HOLD    = 8;
    localparam int REJ_W          = 5;
    localparam int READY_LIMIT    = 63;
    localparam int OUT_W          = 6;
    localparam int CRED_W         = 8;
    localparam int LINK_PERIOD_NS = 40;
    localparam int IC_FILTER_NS   = 160;
    localparam int IC_FILTER      = IC_FILTER_NS / LINK_PERIOD_NS;
    localparam int ICF_W          = 3;

    typedef logic [DATA_W-1:0] pls_word_t;

    typedef struct packed {
        logic               request;
        logic               packet;
        logic               burst;
        pls_word_t          data;
        logic [PAR_W-1:0]   parity;
    } pls_linkin_s;

    typedef enum logic [1:0] {
        EV_IFIELD,
        EV_WORD,
        EV_BURST_END
    } pls_evkind_e;

    typedef struct packed {
        pls_evkind_e        kind;
        logic               first;
        logic               checkOk;
        pls_word_t          data;
    } pls_event_s;

    typedef struct packed {
        logic               connected;
        logic               packet;
        logic               icOk;
        logic               errSeq;
        logic               errParity;
        logic               errCheck;
    } pls_status_s;

    function automatic logic oddParityOk(input pls_word_t d, input logic [PAR_W-1:0] p);
        logic ok;
        ok = 1'b1;
        for (int i = 0; i < PAR_W; i++) begin
            if (^{d[8*i +: 8], p[i]} == 1'b0) begin
                ok = 1'b0;
            end
        end
        return ok;
    endfunction

    function automatic pls_word_t checkSeed(input logic [WCNT_W-1:0] cnt);
        pls_word_t s;
        s = '0;
        s[SEED_W-1:0] = cnt[SEED_W-1:0];
        for (int i = 32; i + SEED_W <= DATA_W; i += 32) begin
            s[i +: SEED_W] = cnt[SEED_W-1:0];
        end
        return s;
    endfunction

    function automatic logic [CRED_W-1:0] gray2bin(input logic [CRED_W-1:0] g);
        logic [CRED_W-1:0] b;
        b = '0;
        b[CRED_W-1] = g[CRED_W-1];
        for (int i = CRED_W - 2; i >= 0; i--) begin
            b[i] = b[i+1] ^ g[i];
        end
        return b;
    endfunction

endpackage

// ### logic/pls_sync.sv
// Two-flop level synchroniser, one bit per lane.
// Assumes each lane is a level or a gray-coded word from a flop in another domain.
`timescale 1ns/1ps
`default_nettype none
module pls_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta;

    always_ff @(posedge clk) begin
        meta <= d;
        q    <= meta;
    end
endmodule
`default_nettype wire

// ### logic/pls_dest.sv
// Destination end of the simplex parallel link: connection handshake, ready flow
// control, burst framing, parity and checkword checks.
// Assumes linkClk is the source's continuous clock; user side runs on clk_sys.
`timescale 1ns/1ps
`default_nettype none
module pls_dest
    import pls_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        sys_rst,
    input  wire logic        clkEn,
    input  wire logic        linkClk,
    input  wire pls_linkin_s linkIn,
    input  wire logic        interconnectIn,
    output logic             connectOut,
    output logic             readyOut,
    input  wire logic        acceptEn,
    input  wire logic        hangupReq,
    input  wire logic        bufFree,
    output logic             rxValid,
    output pls_event_s       rxEvent,
    output pls_status_s      status,
    output logic [1:0]       errCode
);

    typedef enum logic [2:0] {
        LK_LOST,
        LK_DROP,
        LK_IDLE,
        LK_REJECT,
        LK_CONN,
        LK_ERROR
    } pls_lkstate_e;

    // ---------------- link domain ----------------
    logic               lkRst;
    logic               lkEn;
    logic               lkAccept;
    logic               lkHangup;
    logic               lkIcRaw;
    logic [CRED_W-1:0]  lkFreeGray;
    logic [CRED_W-1:0]  lkFreeBin;
    logic [CRED_W-1:0]  lkPending;
    logic [CRED_W-1:0]  sysFreeGray_reg;

    pls_sync #(.W(5)) uLkSync (
        .clk (linkClk),
        .d   ({sys_rst, clkEn, acceptEn, hangupReq, interconnectIn}),
        .q   ({lkRst, lkEn, lkAccept, lkHangup, lkIcRaw})
    );

    pls_sync #(.W(CRED_W)) uCredSync (
        .clk (linkClk),
        .d   (sysFreeGray_reg),
        .q   (lkFreeGray)
    );

    logic               lkIcOk_reg;
    logic [ICF_W-1:0]   lkIcCnt_reg;
    pls_linkin_s        lkPin_reg;
    pls_lkstate_e       lkSt_reg;
    pls_lkstate_e       lkSt_next;
    logic [REJ_W-1:0]   lkRejCnt_reg;
    logic [OUT_W-1:0]   lkOut_reg;
    logic [CRED_W-1:0]  lkUsed_reg;
    logic [WCNT_W-1:0]  lkWcnt_reg;
    pls_word_t          lkCheck_reg;
    logic               lkBurstPrev_reg;
    logic               lkPkt_reg;
    logic               lkErrSeq_reg;
    logic               lkErrPar_reg;
    logic               lkErrChk_reg;
    pls_event_s         lkEv_reg;
    logic               lkEvTgl_reg;

    // interconnect must hold a new level for several periods before it is believed
    always_ff @(posedge linkClk) begin
        if (lkRst) begin
            lkIcOk_reg  <= 1'b0;
            lkIcCnt_reg <= '0;
        end else if (lkEn) begin
            if (lkIcRaw == lkIcOk_reg) begin
                lkIcCnt_reg <= '0;
            end else if (lkIcCnt_reg == ICF_W'(IC_FILTER - 1)) begin
                lkIcOk_reg  <= lkIcRaw;
                lkIcCnt_reg <= '0;
            end else begin
                lkIcCnt_reg <= lkIcCnt_reg + 1'b1;
            end
        end
    end

    // link pins share the link clock, so one capture stage aligns them
    always_ff @(posedge linkClk) begin
        if (lkRst) begin
            lkPin_reg <= '0;
        end else if (lkEn) begin
            lkPin_reg <= linkIn;
        end
    end

    logic lkReq;
    logic lkConnected;
    logic lkStart;
    logic lkCont;
    logic lkFin;
    logic lkParOk;
    logic lkSeqErr;
    logic lkIssue;

    assign lkReq       = lkPin_reg.request && lkIcOk_reg;
    assign lkConnected = (lkSt_reg == LK_CONN) && lkReq;
    assign lkStart     = lkConnected && lkPin_reg.burst && !lkBurstPrev_reg;
    assign lkCont      = lkConnected && lkPin_reg.burst && lkBurstPrev_reg;
    assign lkFin       = lkConnected && !lkPin_reg.burst && lkBurstPrev_reg;
    assign lkParOk     = oddParityOk(lkPin_reg.data, lkPin_reg.parity);
    assign lkFreeBin   = gray2bin(lkFreeGray);
    assign lkPending   = lkFreeBin - lkUsed_reg;

    // burst without credit, burst outside a packet or an overlong burst
    assign lkSeqErr = (lkStart && lkOut_reg == '0)
                   || (lkConnected && lkPin_reg.burst && !lkPin_reg.packet)
                   || (lkCont && lkWcnt_reg == WCNT_W'(BURST_MAX));

    always_comb begin
        lkSt_next = lkSt_reg;
        if (!lkIcOk_reg) begin
            lkSt_next = LK_LOST;
        end else begin
            case (lkSt_reg)
                LK_LOST: begin
                    lkSt_next = LK_DROP;
                end
                LK_DROP, LK_ERROR: begin
                    if (!lkReq) begin
                        lkSt_next = LK_IDLE;
                    end
                end
                LK_IDLE: begin
                    if (lkReq) begin
                        lkSt_next = lkAccept ? LK_CONN : LK_REJECT;
                    end
                end
                LK_REJECT: begin
                    if (!lkReq || lkRejCnt_reg == REJ_W'(REJECT_HOLD - 1)) begin
                        lkSt_next = LK_DROP;
                    end
                end
                LK_CONN: begin
                    if (!lkReq || lkHangup) begin
                        lkSt_next = LK_DROP;
                    end else if (lkSeqErr) begin
                        lkSt_next = LK_ERROR;
                    end
                end
                default: begin
                    lkSt_next = LK_LOST;
                end
            endcase
        end
    end

    always_ff @(posedge linkClk) begin
        if (lkRst) begin
            lkSt_reg <= LK_LOST;
        end else if (lkEn) begin
            lkSt_reg <= lkSt_next;
        end
    end

    // connect is high through acceptance and through the rejection hold
    always_ff @(posedge linkClk) begin
        if (lkRst) begin
            connectOut <= 1'b0;
        end else if (lkEn) begin
            connectOut <= (lkSt_next == LK_CONN) || (lkSt_next == LK_REJECT);
        end
    end

    always_ff @(posedge linkClk) begin
        if (lkRst) begin
            lkRejCnt_reg <= '0;
        end else if (lkEn) begin
            if (lkSt_reg == LK_REJECT) begin
                lkRejCnt_reg <= lkRejCnt_reg + 1'b1;
            end else begin
                lkRejCnt_reg <= '0;
            end
        end
    end

    // one-period ready pulses with a gap, only while the connection stays up
    assign lkIssue = (lkSt_reg == LK_CONN) && (lkSt_next == LK_CONN)
                  && (lkPending != '0) && (lkOut_reg < OUT_W'(READY_LIMIT))
                  && !readyOut;

    always_ff @(posedge linkClk) begin
        if (lkRst) begin
            readyOut <= 1'b0;
        end else if (lkEn) begin
            readyOut <= lkIssue;
        end
    end

    always_ff @(posedge linkClk) begin
        if (lkRst) begin
            lkUsed_reg <= '0;
        end else if (lkEn && lkIssue) begin
            lkUsed_reg <= lkUsed_reg + 1'b1;
        end
    end

    // readies granted but not yet used; empty outside a connection
    always_ff @(posedge linkClk) begin
        if (lkRst) begin
            lkOut_reg <= '0;
        end else if (lkEn) begin
            if (lkSt_reg != LK_CONN) begin
                lkOut_reg <= '0;
            end else if (lkIssue && !(lkStart && lkOut_reg != '0)) begin
                lkOut_reg <= lkOut_reg + 1'b1;
            end else if (!lkIssue && lkStart && lkOut_reg != '0) begin
                lkOut_reg <= lkOut_reg - 1'b1;
            end
        end
    end

    // word count and running column xor of the burst
    always_ff @(posedge linkClk) begin
        if (lkRst) begin
            lkWcnt_reg      <= '0;
            lkCheck_reg     <= '0;
            lkBurstPrev_reg <= 1'b0;
        end else if (lkEn) begin
            lkBurstPrev_reg <= lkConnected && lkPin_reg.burst;
            if (lkStart) begin
                lkWcnt_reg  <= WCNT_W'(1);
                lkCheck_reg <= lkPin_reg.data;
            end else if (lkCont) begin
                lkWcnt_reg  <= lkWcnt_reg + 1'b1;
                lkCheck_reg <= lkCheck_reg ^ lkPin_reg.data;
            end
        end
    end

    always_ff @(posedge linkClk) begin
        if (lkRst) begin
            lkPkt_reg <= 1'b0;
        end else if (lkEn) begin
            lkPkt_reg <= lkConnected && lkPin_reg.packet;
        end
    end

    // error flags hold until the next connection is offered
    always_ff @(posedge linkClk) begin
        if (lkRst) begin
            lkErrSeq_reg <= 1'b0;
            lkErrPar_reg <= 1'b0;
            lkErrChk_reg <= 1'b0;
        end else if (lkEn) begin
            if (lkSt_reg == LK_IDLE && lkReq) begin
                lkErrSeq_reg <= 1'b0;
                lkErrPar_reg <= !lkParOk;
                lkErrChk_reg <= 1'b0;
            end else begin
                if (lkSt_reg == LK_CONN && lkSeqErr) begin
                    lkErrSeq_reg <= 1'b1;
                end
                if ((lkStart || lkCont || lkFin) && !lkParOk) begin
                    lkErrPar_reg <= 1'b1;
                end
                if (lkFin && lkPin_reg.data != (lkCheck_reg ^ checkSeed(lkWcnt_reg))) begin
                    lkErrChk_reg <= 1'b1;
                end
            end
        end
    end

    // received items are posted one per link period with a toggle
    always_ff @(posedge linkClk) begin
        if (lkRst) begin
            lkEv_reg    <= '0;
            lkEvTgl_reg <= 1'b0;
        end else if (lkEn) begin
            if (lkSt_reg == LK_IDLE && lkReq && lkAccept) begin
                lkEv_reg    <= '{EV_IFIELD, 1'b0, lkParOk, lkPin_reg.data};
                lkEvTgl_reg <= !lkEvTgl_reg;
            end else if (lkStart || lkCont) begin
                lkEv_reg    <= '{EV_WORD, lkStart, lkParOk, lkPin_reg.data};
                lkEvTgl_reg <= !lkEvTgl_reg;
            end else if (lkFin) begin
                lkEv_reg    <= '{EV_BURST_END, 1'b0,
                                 lkPin_reg.data == (lkCheck_reg ^ checkSeed(lkWcnt_reg)),
                                 lkPin_reg.data};
                lkEvTgl_reg <= !lkEvTgl_reg;
            end
        end
    end

    // ---------------- system domain ----------------
    logic               sysTgl;
    pls_status_s        sysStat;
    logic               sysTglPrev_reg;
    logic [CRED_W-1:0]  sysFreeBin_reg;
    logic [CRED_W-1:0]  sysFreeNext;

    pls_sync #(.W(7)) uSysSync (
        .clk (clk_sys),
        .d   ({lkEvTgl_reg, connectOut, lkPkt_reg, lkIcOk_reg,
               lkErrSeq_reg, lkErrPar_reg, lkErrChk_reg}),
        .q   ({sysTgl, sysStat})
    );

    assign sysFreeNext = sysFreeBin_reg + CRED_W'(bufFree);

    // freed buffers cross as a gray-coded running count
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            sysFreeBin_reg  <= '0;
            sysFreeGray_reg <= '0;
        end else if (clkEn) begin
            sysFreeBin_reg  <= sysFreeNext;
            sysFreeGray_reg <= sysFreeNext ^ (sysFreeNext >> 1);
        end
    end

    // the event word changes on the same link edge as the toggle and then holds for at least one link period, so it is stable when the toggle lands
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            sysTglPrev_reg <= 1'b0;
            rxValid        <= 1'b0;
            rxEvent        <= '0;
        end else if (clkEn) begin
            sysTglPrev_reg <= sysTgl;
            rxValid        <= sysTgl != sysTglPrev_reg;
            if (sysTgl != sysTglPrev_reg) begin
                rxEvent <= lkEv_reg;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            status  <= '0;
            errCode <= 2'h0;
        end else if (clkEn) begin
            status <= sysStat;
            if (sysStat.errSeq) begin
                errCode <= 2'h1;
            end else if (sysStat.errParity) begin
                errCode <= 2'h2;
            end else if (sysStat.errCheck) begin
                errCode <= 2'h3;
            end else begin
                errCode <= 2'h0;
            end
        end
    end

endmodule
`default_nettype wire

// ### test/pls_dest_monitor.sv
// Checker of the destination's link handshake and user-side outputs.
// Bound into every pls_dest; link and system clocks are ports of the block.
`timescale 1ns/1ps
`default_nettype none
module pls_dest_monitor
    import pls_pkg::*;
(
    input wire logic        clk_sys,
    input wire logic        sys_rst,
    input wire logic        linkClk,
    input wire pls_linkin_s linkIn,
    input wire logic        interconnectIn,
    input wire logic        acceptEn,
    input wire logic        connectOut,
    input wire logic        readyOut,
    input wire logic        rxValid,
    input wire pls_event_s  rxEvent,
    input wire pls_status_s status,
    input wire logic [1:0]  errCode
);
    logic connPrev;
    logic reqLowSeen;
    always_ff @(posedge linkClk) begin
        connPrev <= connectOut;
    end
    // set once request is seen low, cleared when connect falls
    always_ff @(posedge linkClk) begin
        if (sys_rst || !linkIn.request) begin
            reqLowSeen <= 1'b1;
        end else if (connPrev && !connectOut) begin
            reqLowSeen <= 1'b0;
        end
    end
    sequence s_rejectHold;
        connectOut [*8] ##1 !connectOut;
    endsequence
    sequence s_noReady;
        !readyOut [*8];
    endsequence
    a_reject_hold: assert property (@(posedge linkClk) disable iff (sys_rst)
        $rose(connectOut) && !acceptEn |-> s_rejectHold) else $error("reject hold wrong");
    a_reject_ready: assert property (@(posedge linkClk) disable iff (sys_rst)
        $rose(connectOut) && !acceptEn |-> s_noReady) else $error("ready while rejecting");
    a_connect_cause: assert property (@(posedge linkClk) disable iff (sys_rst)
        $rose(connectOut) |-> linkIn.request && $past(linkIn.request) && interconnectIn)
        else $error("connect without request");
    a_ready_conn: assert property (@(posedge linkClk) disable iff (sys_rst)
        readyOut |-> connectOut) else $error("ready without connect");
    a_ready_gap: assert property (@(posedge linkClk) disable iff (sys_rst)
        readyOut |=> !readyOut) else $error("ready pulses adjacent");
    a_reqdrop_conn: assert property (@(posedge linkClk) disable iff (sys_rst)
        connectOut && !linkIn.request |-> ##[1:2] !connectOut) else $error("connect held");
    a_icloss_conn: assert property (@(posedge linkClk) disable iff (sys_rst)
        $fell(interconnectIn) |-> ##[1:8] !connectOut) else $error("connect kept on loss");
    a_reconnect_wait: assert property (@(posedge linkClk) disable iff (sys_rst)
        $rose(connectOut) |-> reqLowSeen) else $error("reconnect without new request");
    a_event_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !rxValid |-> $stable(rxEvent)) else $error("event changed without valid");
    a_seq_wins: assert property (@(posedge clk_sys) disable iff (sys_rst)
        status.errSeq |-> errCode == 2'h1) else $error("sequence error not reported first");
endmodule
bind pls_dest pls_dest_monitor i_mon (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .linkClk(linkClk), .linkIn(linkIn),
    .interconnectIn(interconnectIn), .acceptEn(acceptEn), .connectOut(connectOut),
    .readyOut(readyOut), .rxValid(rxValid), .rxEvent(rxEvent), .status(status),
    .errCode(errCode)
);
`default_nettype wire

// ### test/pls_src_model.sv
// Source end of the link: free-running clock, request, framing, parity, checkword.
// Assumes the bench calls its tasks one at a time from a single process.
`timescale 1ns/1ps
`default_nettype none
module pls_src_model
    import pls_pkg::*;
(
    output logic        linkClk,
    output pls_linkin_s linkIn,
    output logic        interconnectIn,
    input  wire logic   connectOut,
    input  wire logic   readyOut
);
    logic [CRED_W-1:0] credit;
    logic              take;
    initial begin
        linkClk = 1'b0;
        forever #24 linkClk = ~linkClk;
    end
    initial begin
        linkIn = '0;
        interconnectIn = 1'b1;
        take = 1'b0;
    end
    always @(posedge linkClk) begin
        if (!linkIn.request) begin
            credit <= '0;
        end else begin
            credit <= credit + readyOut - take;
        end
    end
    function automatic logic [PAR_W-1:0] oddPar(input pls_word_t d);
        for (int i = 0; i < PAR_W; i++) begin
            oddPar[i] = ~^d[8*i +: 8];
        end
    endfunction
    task automatic put(input logic r, input logic pk, input logic b, input pls_word_t d,
                       input logic bad);
        @(posedge linkClk);
        linkIn <= '{r, pk, b, d, oddPar(d) ^ {{(PAR_W-1){1'b0}}, bad}};
    endtask
    task automatic openConn(input pls_word_t iw);
        int k;
        k = 0;
        while (connectOut !== 1'b0 && k < 40) begin
            @(posedge linkClk);
            k++;
        end
        if (k >= 40) begin
            pls_dest_tb_top.chk(connectOut, 1'b0);
            pls_dest_tb_top.final_report();
        end
        repeat (2) @(posedge linkClk);
        put(1'b1, 1'b0, 1'b0, iw, 1'b0);
    endtask
    // bad below n flips that word's parity, bad equal to n spoils the checkword
    task automatic burst(input int n, input pls_word_t base, input int bad, input logic useCr);
        pls_word_t x;
        int        k;
        k = 0;
        while (useCr && credit == '0 && k < 100) begin
            @(posedge linkClk);
            k++;
        end
        if (k >= 100) begin
            pls_dest_tb_top.chk(credit, 1);
            pls_dest_tb_top.final_report();
        end
        x = '0;
        x[7:0] = n[7:0];
        put(1'b1, 1'b1, 1'b0, ~linkIn.data, 1'b0);
        for (int i = 0; i < n; i++) begin
            put(1'b1, 1'b1, 1'b1, base + i, i == bad);
            take <= (i == 0) && useCr;
            x ^= base + i;
        end
        put(1'b1, 1'b1, 1'b0, x ^ (n == bad), 1'b0);
        take <= 1'b0;
        put(1'b1, 1'b0, 1'b0, ~x, 1'b0);
    endtask
    task automatic closeConn;
        put(1'b0, 1'b0, 1'b0, ~linkIn.data, 1'b0);
    endtask
    task automatic setIc(input logic v);
        @(posedge linkClk);
        interconnectIn <= v;
        if (!v) begin
            closeConn();
        end
    endtask
endmodule
`default_nettype wire

// ### test/pls_dest_tb_top.sv
// Self-checking bench of the link destination against a source model.
// Assumes the checker is bound into the destination from its own file.
`timescale 1ns/1ps
`default_nettype none
module pls_dest_tb_top
    import pls_pkg::*;
;
    logic        clk_sys;
    logic        sys_rst;
    logic        clkEn;
    logic        acceptEn;
    logic        hangupReq;
    logic        bufFree;
    wire logic   linkClk;
    wire logic   interconnectIn;
    pls_linkin_s linkIn;
    logic        connectOut;
    logic        readyOut;
    logic        rxValid;
    pls_event_s  rxEvent;
    pls_status_s status;
    logic [1:0]  errCode;
    int          n_fail;
    int          cmp_count;
    int          readyCnt;
    int          pktSeen;
    pls_event_s  evQ[$];
    pls_dest i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .clkEn(clkEn), .linkClk(linkClk),
        .linkIn(linkIn), .interconnectIn(interconnectIn), .connectOut(connectOut),
        .readyOut(readyOut), .acceptEn(acceptEn), .hangupReq(hangupReq), .bufFree(bufFree),
        .rxValid(rxValid), .rxEvent(rxEvent), .status(status), .errCode(errCode));
    pls_src_model i_src (.linkClk(linkClk), .linkIn(linkIn), .interconnectIn(interconnectIn),
        .connectOut(connectOut), .readyOut(readyOut));
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    always @(negedge clk_sys) if (rxValid === 1'b1) evQ.push_back(rxEvent);
    always @(negedge linkClk) if (readyOut === 1'b1) readyCnt++;
    always @(negedge clk_sys) if (status.packet === 1'b1) pktSeen++;
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        cmp_count++;
        if (got !== exp) begin
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
            n_fail++;
        end
    endtask
    task automatic final_report;
        $display("comparisons=%0d mismatches=%0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic sysWait(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic waitConn(input logic lvl, input int lim);
        int k;
        k = 0;
        while (connectOut !== lvl && k < lim) begin
            @(negedge linkClk);
            k++;
        end
        if (k >= lim) begin
            chk(connectOut, lvl);
            final_report();
        end
    endtask
    task automatic freeBufs(input int n);
        repeat (n) begin
            @(posedge clk_sys);
            bufFree <= 1'b1;
            @(posedge clk_sys);
            bufFree <= 1'b0;
            sysWait(4);
        end
    endtask
    task automatic openConn(input pls_word_t iw, input logic acc);
        @(posedge clk_sys);
        acceptEn <= acc;
        sysWait(30);
        evQ.delete();
        i_src.openConn(iw);
        waitConn(1'b1, 6);
    endtask
    task automatic t_accept;
        openConn(32'h1234_5678, 1'b1);
        sysWait(40);
        chk(evQ.size(), 1);
        chk(evQ[0].kind, EV_IFIELD);
        chk(evQ[0].data, 32'h1234_5678);
        chk(evQ[0].checkOk, 1'b1);
        chk(status.connected, 1'b1);
        // a buffer freed while frozen must not become a ready
        clkEn <= 1'b0;
        freeBufs(1);
        clkEn <= 1'b1;
    endtask
    task automatic t_bursts;
        freeBufs(2);
        evQ.delete();
        i_src.burst(3, 32'hA5A5_0000, 9, 1'b1);
        sysWait(60);
        chk(i_src.credit, 1);
        chk(evQ.size(), 4);
        for (int i = 0; i < 3; i++) begin
            chk(evQ[i].data, 32'hA5A5_0000 + i);
            chk(evQ[i].first, i == 0);
        end
        chk(evQ[3].kind, EV_BURST_END);
        chk(evQ[3].checkOk, 1'b1);
        chk(pktSeen != 0, 1'b1);
        i_src.burst(1, 32'h0F0F_0001, 1, 1'b1);
        sysWait(60);
        chk(errCode, 2'h3);
        chk(status.errCheck, 1'b1);
    endtask
    task automatic t_seq;
        i_src.burst(1, 32'h0000_0001, 9, 1'b0);
        waitConn(1'b0, 10);
        sysWait(20);
        chk(status.errSeq, 1'b1);
        chk(errCode, 2'h1);
        i_src.closeConn();
    endtask
    task automatic t_reject;
        openConn(32'h0000_00A0, 1'b0);
        readyCnt = 0;
        freeBufs(1);
        waitConn(1'b0, 12);
        chk(readyCnt, 0);
        chk(errCode, 2'h0);
        i_src.closeConn();
    endtask
    task automatic t_hangup;
        openConn(32'h0000_00B0, 1'b1);
        sysWait(60);
        chk(i_src.credit, 1);
        freeBufs(1);
        i_src.burst(2, 32'h3C3C_0000, 0, 1'b1);
        sysWait(60);
        chk(errCode, 2'h2);
        chk(status.errParity, 1'b1);
        hangupReq <= 1'b1;
        waitConn(1'b0, 10);
        @(posedge clk_sys);
        hangupReq <= 1'b0;
        repeat (20) @(negedge linkClk);
        chk(connectOut, 1'b0);
        i_src.closeConn();
    endtask
    task automatic t_ic;
        openConn(32'h0000_00C0, 1'b1);
        i_src.setIc(1'b0);
        waitConn(1'b0, 10);
        sysWait(100);
        chk(status.icOk, 1'b0);
        i_src.setIc(1'b1);
        repeat (12) @(posedge linkClk);
        chk(status.icOk, 1'b1);
    endtask
    initial begin
        sys_rst = 1'b1;
        clkEn = 1'b1;
        acceptEn = 1'b1;
        hangupReq = 1'b0;
        bufFree = 1'b0;
        n_fail = 0;
        cmp_count = 0;
        readyCnt = 0;
        sysWait(50);
        sys_rst <= 1'b0;
        repeat (12) @(posedge linkClk);
        t_accept();
        t_bursts();
        t_seq();
        t_reject();
        t_hangup();
        t_ic();
        final_report();
    end
endmodule
`default_nettype wire
